// ---- core/ftxirq_alarm_sender.sv ----
// alarm code sender: repeats one 16-bit word a fixed number of times
// assumes slot pulses mark each outgoing alarm bit opportunity
`timescale 1ns/1ps
`default_nettype none
module ftxirq_alarm_sender #(
  parameter int REPEATS = ftxirq_pkg::ALARM_REPEATS
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic start,
  input wire logic [5:0] code,
  input wire logic slot,
  output logic bit_out,
  output ftxirq_pkg::ftxirq_stat_type stat
);
  import ftxirq_pkg::*;

  logic [15:0] word;
  logic [3:0] bit_cnt;
  logic [3:0] rep_cnt;
  wire last_bit = (bit_cnt == 4'(ALARM_WORD_BITS - 1));
  wire last_rep = (rep_cnt == 4'(REPEATS - 1));
  // code framed by zeros, then the all-ones fill, sent msb first
  wire [15:0] frame_word = {1'b0, code, 1'b0, ALARM_FILL};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      word <= 16'h0000;
      bit_cnt <= 4'h0;
      rep_cnt <= 4'h0;
      bit_out <= 1'b1;
      stat <= '0;
    end else if (ce) begin
      stat.done <= 1'b0;
      if (!stat.busy && start) begin
        word <= frame_word;
        bit_cnt <= 4'h0;
        rep_cnt <= 4'h0;
        stat.busy <= 1'b1;
      end else if (stat.busy && slot) begin
        bit_out <= word[15 - bit_cnt];
        bit_cnt <= last_bit ? 4'h0 : bit_cnt + 4'h1;
        if (last_bit) begin
          rep_cnt <= rep_cnt + 4'h1;
          if (last_rep) begin
            stat.busy <= 1'b0;
            stat.done <= 1'b1;
          end
        end
      end
    end
  end
endmodule // ftxirq_alarm_sender
`default_nettype wire

// ---- core/ftxirq_frame_sender.sv ----
// data-link frame sender: flag, stuffed message, stuffed check sequence, flag
// assumes the message buffer answers rd_index in the same cycle
`timescale 1ns/1ps
`default_nettype none
module ftxirq_frame_sender (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic start,
  input wire logic [6:0] length,
  input wire logic slot,
  input wire logic [7:0] rd_byte,
  output logic [6:0] rd_index,
  output logic bit_out,
  output ftxirq_pkg::ftxirq_stat_type stat
);
  import ftxirq_pkg::*;

  typedef enum logic [2:0] {
    FS_IDLE = 3'b000,
    FS_OPEN = 3'b001,
    FS_DATA = 3'b011,
    FS_FCS = 3'b010,
    FS_CLOSE = 3'b110
  } ftxirq_fs_type;

  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic b);
    crc_step = (c[0] ^ b) ? ((c >> 1) ^ CRC_POLY_REFL) : (c >> 1);
  endfunction

  ftxirq_fs_type state;
  logic [15:0] sreg;
  logic [15:0] crc;
  logic [3:0] cnt;
  logic [2:0] ones;
  wire stuff = (ones == STUFF_RUN);
  wire cur = sreg[0];
  wire [15:0] crc_next = crc_step(crc, cur);
  wire byte_end = (cnt == 4'h7);
  wire fcs_end = (cnt == 4'hF);
  wire msg_end = (rd_index == length);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= FS_IDLE;
      sreg <= 16'h0000;
      crc <= CRC_INIT;
      cnt <= 4'h0;
      ones <= 3'h0;
      rd_index <= 7'h00;
      bit_out <= 1'b1;
      stat <= '0;
    end else if (ce) begin
      stat.done <= 1'b0;
      unique case (state)
        FS_IDLE: begin
          if (start) begin
            state <= FS_OPEN;
            sreg <= {8'h00, HDLC_FLAG};
            crc <= CRC_INIT;
            cnt <= 4'h0;
            ones <= 3'h0;
            rd_index <= 7'h00;
            stat.busy <= 1'b1;
          end else if (slot) begin
            // line returns to idle ones once the closing flag has gone out
            bit_out <= 1'b1;
          end
        end
        FS_OPEN, FS_CLOSE: begin
          // a run of ones that ends the check sequence still takes its zero
          if (slot && stuff) begin
            bit_out <= 1'b0;
            ones <= 3'h0;
          end else if (slot) begin
            bit_out <= cur;
            sreg <= sreg >> 1;
            cnt <= cnt + 4'h1;
            if (byte_end) begin
              cnt <= 4'h0;
              if (state == FS_OPEN) begin
                state <= FS_DATA;
                sreg <= {8'h00, rd_byte};
                rd_index <= rd_index + 7'h01;
              end else begin
                state <= FS_IDLE;
                stat.busy <= 1'b0;
                stat.done <= 1'b1;
              end
            end
          end
        end
        FS_DATA, FS_FCS: begin
          if (slot && stuff) begin
            bit_out <= 1'b0;
            ones <= 3'h0;
          end else if (slot) begin
            bit_out <= cur;
            ones <= cur ? ones + 3'h1 : 3'h0;
            sreg <= sreg >> 1;
            cnt <= cnt + 4'h1;
            if (state == FS_DATA) begin
              crc <= crc_next;
              if (byte_end && msg_end) begin
                state <= FS_FCS;
                cnt <= 4'h0;
                sreg <= ~crc_next;
              end else if (byte_end) begin
                cnt <= 4'h0;
                sreg <= {8'h00, rd_byte};
                rd_index <= rd_index + 7'h01;
              end
            end else if (fcs_end) begin
              state <= FS_CLOSE;
              cnt <= 4'h0;
              sreg <= {8'h00, HDLC_FLAG};
            end
          end
        end
        default: state <= FS_IDLE;
      endcase
    end
  end
endmodule // ftxirq_frame_sender
`default_nettype wire

// ---- core/ftxirq_tx_irq.sv ----
// transmit completion interrupt block: AHB-Lite registers, message buffer,
// alarm code and data-link senders, two-level interrupt gating
// assumes the framer supplies bit-slot pulses for both outgoing streams
//
// Behaviour
// - block enable off masks all transmit interrupts
// - source enable off masks that source
// - block enable is bit 1 at 0x04
// - alarm interrupt enable is bit 4 at 0x31
// - alarm code fetched into sixteen-bit word
// - alarm word sent ten times back to back
// - alarm done flag bit 3 after tenth
// - interrupt pin driven low on completion
// - alarm sender ready again after finishing
// - data-link interrupt enable is bit 1 at 0x34
// - message read from buffer 0x86 to 0xDD
// - zero inserted after five consecutive ones
// - check sequence computed and appended after message
// - stuffed message wrapped in flagged frame
// - frame sent serially in data-link bit slots
// - data-link done flag bit 0 after frame
//
// The AHB-Lite interface to the registers was decided locally.
`timescale 1ns/1ps
`default_nettype none
module ftxirq_tx_irq #(
  parameter int BUF_BYTES = ftxirq_pkg::BUF_DEPTH,
  parameter int ALARM_REPEAT_COUNT = ftxirq_pkg::ALARM_REPEATS
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic alarm_slot,
  input wire logic datalink_slot,
  output logic far_end_alarm_code,
  output logic frame_datalink_bits,
  output logic alarm_code_sending,
  output logic datalink_sending,
  output logic irq_n
);
  import ftxirq_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // register state

  logic [7:0] block_irq_enable;
  logic tx_block_irq_en;
  logic alarm_code_irq_en;
  logic alarm_code_sender_on;
  logic alarm_code_send_cmd;
  logic alarm_code_done_flag;
  logic [5:0] alarm_code;
  logic datalink_irq_en;
  logic datalink_send_cmd;
  logic datalink_done_flag;
  logic [6:0] datalink_length;
  logic [7:0] msg_buf [BUF_BYTES];

  ftxirq_req_type req;
  logic pend;
  logic alarm_start;
  logic dl_start;

  ftxirq_stat_type alarm_stat;
  ftxirq_stat_type dl_stat;
  logic alarm_bit;
  logic dl_bit;
  logic [6:0] dl_rd_index;

  ////////////////////////////////////////////////////////////////////////////
  // bus decode

  function automatic logic is_buf(input logic [7:0] idx);
    is_buf = (idx >= IDX_BUF_FIRST) && (idx <= IDX_BUF_LAST);
  endfunction

  wire addr_take = hsel && htrans[1] && hready;
  wire [7:0] take_index = haddr[9:2];
  wire wr_now = pend && req.write;
  wire rd_now = pend && !req.write;
  wire wr_block = wr_now && (req.index == IDX_BLOCK_IRQ_EN);
  wire wr_alarm = wr_now && (req.index == IDX_ALARM_CTRL);
  wire wr_code = wr_now && (req.index == IDX_ALARM_CODE);
  wire wr_dl = wr_now && (req.index == IDX_DL_STATUS);
  wire wr_len = wr_now && (req.index == IDX_DL_LENGTH);
  wire wr_buf = wr_now && is_buf(req.index);
  wire rd_alarm = rd_now && (req.index == IDX_ALARM_CTRL);
  wire rd_dl = rd_now && (req.index == IDX_DL_STATUS);
  wire [6:0] buf_slot = 7'(req.index - IDX_BUF_FIRST);

  // a length of zero or beyond the buffer is taken as a full buffer
  wire len_bad = (datalink_length == 7'h00) || (datalink_length > 7'(BUF_BYTES));
  wire [6:0] eff_length = len_bad ? 7'(BUF_BYTES) : datalink_length;
  wire [7:0] dl_rd_byte = msg_buf[dl_rd_index];

  wire [7:0] alarm_view = {3'b000, alarm_code_irq_en, alarm_code_done_flag,
                           alarm_code_sender_on, alarm_code_send_cmd,
                           alarm_stat.busy};
  wire [7:0] dl_view = {4'h0, datalink_send_cmd, dl_stat.busy,
                        datalink_irq_en, datalink_done_flag};

  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    if (is_buf(req.index)) begin
      rd_mux = msg_buf[buf_slot];
    end else begin
      unique case (req.index)
        IDX_BLOCK_IRQ_EN: rd_mux = block_irq_enable;
        IDX_ALARM_CTRL: rd_mux = alarm_view;
        IDX_ALARM_CODE: rd_mux = {2'b00, alarm_code};
        IDX_DL_STATUS: rd_mux = dl_view;
        IDX_DL_LENGTH: rd_mux = {1'b0, datalink_length};
        default: rd_mux = 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave: one wait state for every transfer

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      req <= '0;
      pend <= 1'b0;
      hreadyout <= 1'b1;
      hrdata <= 32'h0000_0000;
      hresp <= 1'b0;
    end else if (ce) begin
      pend <= addr_take;
      hreadyout <= !addr_take;
      if (addr_take) begin
        req <= '{write: hwrite, index: take_index};
      end
      if (rd_now) begin
        hrdata <= {24'h000000, rd_mux};
      end
    end
  end

  always_ff @(posedge hclk) begin
    if (ce && wr_buf) begin
      msg_buf[buf_slot] <= hwdata[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control registers

  assign tx_block_irq_en = block_irq_enable[BIT_TX_BLOCK_IRQ_EN];
  // a command starts its sender only when that sender is idle
  assign alarm_start = wr_alarm && hwdata[BIT_ALARM_CMD] && hwdata[BIT_ALARM_ON]
                       && !alarm_stat.busy;
  assign dl_start = wr_dl && hwdata[BIT_DL_CMD] && !dl_stat.busy;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      block_irq_enable <= RST_BLOCK_IRQ_EN;
      alarm_code_irq_en <= 1'b0;
      alarm_code_sender_on <= 1'b0;
      alarm_code_send_cmd <= 1'b0;
      alarm_code <= RST_ALARM_CODE;
      datalink_irq_en <= 1'b0;
      datalink_send_cmd <= 1'b0;
      datalink_length <= RST_DL_LENGTH;
    end else if (ce) begin
      if (wr_block) begin
        // only bits 1 and 0 are writable
        block_irq_enable <= {6'h00, hwdata[1:0]};
      end
      if (wr_alarm) begin
        alarm_code_irq_en <= hwdata[BIT_ALARM_IRQ_EN];
        alarm_code_sender_on <= hwdata[BIT_ALARM_ON];
        alarm_code_send_cmd <= hwdata[BIT_ALARM_CMD];
      end else if (alarm_stat.done) begin
        alarm_code_send_cmd <= 1'b0;
      end
      if (wr_code) begin
        alarm_code <= hwdata[5:0];
      end
      if (wr_dl) begin
        datalink_irq_en <= hwdata[BIT_DL_IRQ_EN];
        datalink_send_cmd <= hwdata[BIT_DL_CMD];
      end else if (dl_stat.done) begin
        datalink_send_cmd <= 1'b0;
      end
      if (wr_len) begin
        datalink_length <= hwdata[6:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // completion flags: set wins over a clear by read or by writing one

  wire alarm_clr = rd_alarm || (wr_alarm && hwdata[BIT_ALARM_DONE]);
  wire dl_clr = rd_dl || (wr_dl && hwdata[BIT_DL_DONE]);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      alarm_code_done_flag <= 1'b0;
      datalink_done_flag <= 1'b0;
    end else if (ce) begin
      if (alarm_stat.done) begin
        alarm_code_done_flag <= 1'b1;
      end else if (alarm_clr) begin
        alarm_code_done_flag <= 1'b0;
      end
      if (dl_stat.done) begin
        datalink_done_flag <= 1'b1;
      end else if (dl_clr) begin
        datalink_done_flag <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt pin and stream outputs

  wire alarm_irq = alarm_code_done_flag && alarm_code_irq_en;
  wire dl_irq = datalink_done_flag && datalink_irq_en;
  wire next_irq_n = !(tx_block_irq_en && (alarm_irq || dl_irq));

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_n <= 1'b1;
      far_end_alarm_code <= 1'b1;
      frame_datalink_bits <= 1'b1;
      alarm_code_sending <= 1'b0;
      datalink_sending <= 1'b0;
    end else if (ce) begin
      irq_n <= next_irq_n;
      far_end_alarm_code <= alarm_bit;
      frame_datalink_bits <= dl_bit;
      alarm_code_sending <= alarm_stat.busy;
      datalink_sending <= dl_stat.busy;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // senders

  ftxirq_alarm_sender #(
    .REPEATS(ALARM_REPEAT_COUNT)
  ) u_alarm (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(ce),
    .start(alarm_start),
    .code(alarm_code),
    .slot(alarm_slot),
    .bit_out(alarm_bit),
    .stat(alarm_stat)
  );

  ftxirq_frame_sender u_frame (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(ce),
    .start(dl_start),
    .length(eff_length),
    .slot(datalink_slot),
    .rd_byte(dl_rd_byte),
    .rd_index(dl_rd_index),
    .bit_out(dl_bit),
    .stat(dl_stat)
  );
endmodule // ftxirq_tx_irq
`default_nettype wire

// ---- include/ftxirq_pkg.sv ----
// shared constants and types of the transmit message completion interrupt block
// assumes one 100 MHz clock domain and a 32-bit AHB-Lite register bus
package ftxirq_pkg;
  // register indices as printed; byte address is four times the index
  localparam logic [7:0] IDX_BLOCK_IRQ_EN = 8'h04;
  localparam logic [7:0] IDX_ALARM_CTRL = 8'h31;
  localparam logic [7:0] IDX_ALARM_CODE = 8'h32;
  localparam logic [7:0] IDX_DL_STATUS = 8'h34;
  localparam logic [7:0] IDX_DL_LENGTH = 8'h35;
  localparam logic [7:0] IDX_BUF_FIRST = 8'h86;
  localparam logic [7:0] IDX_BUF_LAST = 8'hDD;
  localparam int BUF_DEPTH = 88;
  // field positions
  localparam int BIT_TX_BLOCK_IRQ_EN = 1;
  localparam int BIT_ALARM_IRQ_EN = 4;
  localparam int BIT_ALARM_DONE = 3;
  localparam int BIT_ALARM_ON = 2;
  localparam int BIT_ALARM_CMD = 1;
  localparam int BIT_ALARM_BUSY = 0;
  localparam int BIT_DL_CMD = 3;
  localparam int BIT_DL_BUSY = 2;
  localparam int BIT_DL_IRQ_EN = 1;
  localparam int BIT_DL_DONE = 0;
  // reset values
  localparam logic [7:0] RST_BLOCK_IRQ_EN = 8'h00;
  localparam logic [5:0] RST_ALARM_CODE = 6'h00;
  localparam logic [6:0] RST_DL_LENGTH = 7'h58;
  // message framing
  localparam int ALARM_REPEATS = 10;
  localparam int ALARM_WORD_BITS = 16;
  localparam logic [7:0] ALARM_FILL = 8'hFF;
  localparam logic [7:0] HDLC_FLAG = 8'h7E;
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [15:0] CRC_POLY_REFL = 16'h8408;
  localparam logic [2:0] STUFF_RUN = 3'h5;

  // captured AHB address phase
  typedef struct packed {
    logic write;
    logic [7:0] index;
  } ftxirq_req_type;

  // sender report towards the register file
  typedef struct packed {
    logic busy;
    logic done;
  } ftxirq_stat_type;
endpackage

// ---- sim/ftxirq_far_end.sv ----
// far-end model: framer bit slots and the remote receiver of both streams
// assumes each serial bit is settled three edges after its slot is sampled
`timescale 1ns/1ps
`default_nettype none
module ftxirq_far_end (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [3:0] period,
  input wire logic alarm_bit,
  input wire logic dl_bit,
  output logic alarm_slot,
  output logic datalink_slot
);
  logic [3:0] cnt;
  logic [2:0] seen;
  logic al_q[$];
  logic dl_q[$];
  // period of at least four keeps each bit steady for the capture point
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt <= 4'h0;
      {alarm_slot, datalink_slot} <= 2'h0;
      seen <= 3'h0;
    end else begin
      alarm_slot <= (cnt == 4'h0);
      datalink_slot <= (cnt == 4'h0);
      cnt <= (cnt == 4'h0) ? period - 4'h1 : cnt - 4'h1;
      seen <= {seen[1:0], alarm_slot};
      if (seen[2]) begin
        al_q.push_back(alarm_bit);
        dl_q.push_back(dl_bit);
      end
    end
  end
endmodule // ftxirq_far_end
`default_nettype wire

// ---- sim/ftxirq_tx_irq_monitor.sv ----
// assertion checker for the transmit completion interrupt block
// assumes it is bound to the top module and sees only its ports
`timescale 1ns/1ps
`default_nettype none
module ftxirq_tx_irq_monitor #(
  parameter int BUF_BYTES = 88,
  parameter int ALARM_REPEAT_COUNT = 10
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic alarm_slot,
  input wire logic alarm_code_sending,
  input wire logic datalink_sending,
  input wire logic irq_n
);
  import ftxirq_pkg::*;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic wr_pend, blk_en, al_en, dl_en;
  logic [7:0] wr_idx;
  logic go_d;
  logic [8:0] slots;
  wire take = hsel & htrans[1] & hready & ce;
  wire go_wr = wr_pend & (wr_idx == IDX_ALARM_CTRL) & hwdata[BIT_ALARM_CMD] & hwdata[BIT_ALARM_ON];
  //////////////////////////////////////////////////////////////////////////////
  // shadow enables follow the write data phase, as the registers do
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {wr_pend, blk_en, al_en, dl_en} <= 4'h0;
      wr_idx <= 8'h00;
      go_d <= 1'b0;
      slots <= 9'h000;
    end else if (ce) begin
      wr_pend <= take & hwrite;
      wr_idx <= haddr[9:2];
      go_d <= go_wr;
      if (wr_pend && wr_idx == IDX_BLOCK_IRQ_EN) blk_en <= hwdata[BIT_TX_BLOCK_IRQ_EN];
      if (wr_pend && wr_idx == IDX_ALARM_CTRL) al_en <= hwdata[BIT_ALARM_IRQ_EN];
      if (wr_pend && wr_idx == IDX_DL_STATUS) dl_en <= hwdata[BIT_DL_IRQ_EN];
      if (go_wr) slots <= 9'h000;
      // go_d covers the cycle before the registered busy output rises
      else if (alarm_slot && (alarm_code_sending || go_d)) slots <= slots + 9'h001;
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  a_block_gate: assert property (!$past(blk_en) |-> irq_n)
    else $error("interrupt raised with block enable off");
  a_source_gate: assert property (!$past(al_en) && !$past(dl_en) |-> irq_n)
    else $error("interrupt raised with both sources off");
  a_alarm_irq: assert property ($fell(alarm_code_sending) && blk_en && al_en |-> ##[0:3] !irq_n)
    else $error("alarm completion gave no interrupt");
  a_link_irq: assert property ($fell(datalink_sending) && blk_en && dl_en |-> ##[0:3] !irq_n)
    else $error("frame completion gave no interrupt");
  a_ten_words: assert property ($fell(alarm_code_sending) |-> slots == ALARM_REPEAT_COUNT * 16)
    else $error("alarm send used a wrong slot count");
  a_sender_restart: assert property (go_wr && !alarm_code_sending |-> ##[1:4] alarm_code_sending)
    else $error("alarm sender did not restart");
  a_bus_wait: assert property (take |=> !hreadyout ##1 hreadyout)
    else $error("bus answer timing wrong");
  a_resp_okay: assert property (hreadyout |-> !hresp && hrdata[31:8] == 24'h000000)
    else $error("bad response or read data");
  c_alarm_done: cover property ($fell(alarm_code_sending));
  c_link_done: cover property ($fell(datalink_sending));
  c_irq_low: cover property ($fell(irq_n));
endmodule // ftxirq_tx_irq_monitor
bind ftxirq_tx_irq ftxirq_tx_irq_monitor #(.BUF_BYTES(BUF_BYTES),
  .ALARM_REPEAT_COUNT(ALARM_REPEAT_COUNT)) u_monitor (.hclk(hclk), .hresetn(hresetn),
  .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
  .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .alarm_slot(alarm_slot), .alarm_code_sending(alarm_code_sending),
  .datalink_sending(datalink_sending), .irq_n(irq_n));
`default_nettype wire

// ---- sim/ftxirq_tx_irq_tb.sv ----
// self-checking bench of the transmit completion interrupt block
// assumes the design package and the far-end model are compiled first
`timescale 1ns/1ps
`default_nettype none
module ftxirq_tx_irq_tb;
  import ftxirq_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, al_slot, dl_slot;
  logic al_bit, dl_bit, al_busy, dl_busy, irq_n;
  logic [31:0] haddr, hwdata, hrdata, rd, seed;
  logic [1:0] htrans;
  logic [3:0] period;
  logic [15:0] crc;
  logic [7:0] b;
  logic bq[$];
  logic [7:0] ix[5] = '{8'h04, 8'h31, 8'h34, 8'h35, 8'h40};
  logic [7:0] rv[5] = '{8'h00, 8'h00, 8'h00, 8'h58, 8'h00};
  int n_fail, check_count, run, len;
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  ftxirq_tx_irq dut (.hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .alarm_slot(al_slot),
    .datalink_slot(dl_slot), .far_end_alarm_code(al_bit), .frame_datalink_bits(dl_bit),
    .alarm_code_sending(al_busy), .datalink_sending(dl_busy), .irq_n(irq_n));
  ftxirq_far_end far (.hclk(hclk), .hresetn(hresetn), .period(period), .alarm_bit(al_bit),
    .dl_bit(dl_bit), .alarm_slot(al_slot), .datalink_slot(dl_slot));
  //////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {1'b0, s[31:1]} ^ (s[0] ? 32'h80200003 : 32'h00000000);
  endfunction
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] v);
    for (int i = 0; i < 8; i++) c = {1'b0, c[15:1]} ^ ((c[0] ^ v[i]) ? CRC_POLY_REFL : 16'h0000);
    return c;
  endfunction
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic fail_out(input string m);
    n_fail++;
    $display("[ERR] %0t %s", $time, m);
    summarize();
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t %s got %h expected %h", $time, m, got, exp);
    end
  endtask
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (n >= 50) fail_out("bus hang");
  endtask
  // one single transfer: address phase, then data phase; read data lands in rd
  task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {22'h000000, idx, 2'h0};
    hwrite <= w;
    htrans <= 2'h2;
    wait_ready();
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
  endtask
  task automatic wait_busy(input bit dl);
    int n;
    n = 0;
    while ((dl ? dl_busy : al_busy) !== 1'b1 && n < 20) begin
      @(posedge hclk);
      n++;
    end
    if (n >= 20) fail_out("sender never started");
    n = 0;
    while ((dl ? dl_busy : al_busy) !== 1'b0 && n < 5000) begin
      @(posedge hclk);
      n++;
    end
    if (n >= 5000) fail_out("sender never finished");
    repeat (4) @(posedge hclk);
  endtask
  task automatic push_byte(input logic [7:0] v, input bit raw);
    for (int i = 0; i < 8; i++) begin
      bq.push_back(v[i]);
      run = (v[i] && !raw) ? run + 1 : 0;
      if (run == 5) begin
        bq.push_back(1'b0);
        run = 0;
      end
    end
  endtask
  // idle ones before the first zero are not part of the message
  task automatic cmp_stream(input bit dl);
    logic got[$];
    got = dl ? far.dl_q : far.al_q;
    while (got.size() > 0 && got[0] === 1'b1) void'(got.pop_front());
    chk(32'(got.size() >= bq.size()), 32'h1, "stream too short");
    foreach (bq[i]) if (i < got.size()) chk(32'(got[i]), 32'(bq[i]), "stream bit");
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    {hresetn, hsel, hwrite} = 3'h0;
    {haddr, hwdata, htrans} = 66'h0;
    period = 4'h4;
    seed = 32'hC38E7A77;
    n_fail = 0;
    check_count = 0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    foreach (ix[i]) begin
      bus(1'b0, ix[i], 32'h0);
      chk(rd, {24'h0, rv[i]}, "reset value");
    end
    bus(1'b1, IDX_BLOCK_IRQ_EN, 32'hFFFFFFFF);
    bus(1'b0, IDX_BLOCK_IRQ_EN, 32'h0);
    chk(rd, 32'h3, "block enable readback");
    bus(1'b1, IDX_ALARM_CTRL, 32'h10);
    bus(1'b0, IDX_ALARM_CTRL, 32'h0);
    chk(rd, 32'h10, "alarm enable readback");
    bus(1'b1, IDX_DL_STATUS, 32'h2);
    bus(1'b0, IDX_DL_STATUS, 32'h0);
    chk(rd, 32'h2, "link enable readback");
    bus(1'b1, 8'h40, 32'hFFFFFFFF);
    bus(1'b0, 8'h40, 32'h0);
    chk(rd, 32'h0, "unmapped read");
    $display("register test done");
    for (int c = 0; c < 4; c++) begin
      seed = lfsr(seed);
      period <= 4'h4 + {1'b0, seed[10:8]};
      bus(1'b1, IDX_BLOCK_IRQ_EN, {30'h0, c[1], 1'b0});
      bus(1'b1, IDX_ALARM_CODE, {26'h0, seed[5:0]});
      bq.delete();
      // expected word: zero, code msb first, zero, then the all-ones fill
      for (int r = 0; r < ALARM_REPEATS; r++) begin
        for (int i = 15; i >= 0; i--) begin
          if (i == 15 || i == 8) bq.push_back(1'b0);
          else if (i > 8) bq.push_back(seed[i - 9]);
          else bq.push_back(ALARM_FILL[i]);
        end
      end
      far.al_q.delete();
      bus(1'b1, IDX_ALARM_CTRL, {27'h0, c[0], 4'h6});
      wait_busy(1'b0);
      chk(32'(irq_n), 32'(!(c[1] & c[0])), "pin after alarm");
      cmp_stream(1'b0);
      bus(1'b0, IDX_ALARM_CTRL, 32'h0);
      chk(rd, {27'h0, c[0], 4'hC}, "alarm status");
      bus(1'b0, IDX_ALARM_CTRL, 32'h0);
      chk(rd, {27'h0, c[0], 4'h4}, "alarm status reread");
      repeat (3) @(posedge hclk);
      chk(32'(irq_n), 32'h1, "pin release");
      $display("alarm test %0d done", c);
    end
    for (int c = 0; c < 4; c++) begin
      seed = lfsr(seed);
      period <= 4'h4 + {1'b0, seed[10:8]};
      len = 1 + (seed[1:0] % 3);
      bq.delete();
      run = 0;
      crc = CRC_INIT;
      push_byte(HDLC_FLAG, 1'b1);
      for (int i = 0; i < len; i++) begin
        seed = lfsr(seed);
        b = (i == 0) ? 8'hFF : seed[7:0];
        bus(1'b1, IDX_BUF_FIRST + 8'(i), {24'h0, b});
        push_byte(b, 1'b0);
        crc = crc_step(crc, b);
      end
      crc = ~crc;
      push_byte(crc[7:0], 1'b0);
      push_byte(crc[15:8], 1'b0);
      push_byte(HDLC_FLAG, 1'b1);
      bus(1'b1, IDX_DL_LENGTH, 32'(len));
      bus(1'b1, IDX_BLOCK_IRQ_EN, {30'h0, c[1], 1'b0});
      far.dl_q.delete();
      bus(1'b1, IDX_DL_STATUS, {28'h0, 2'h2, c[0], 1'b0});
      wait_busy(1'b1);
      chk(32'(irq_n), 32'(!(c[1] & c[0])), "pin after frame");
      cmp_stream(1'b1);
      bus(1'b0, IDX_DL_STATUS, 32'h0);
      chk(rd & 32'h7, {29'h0, 1'b0, c[0], 1'b1}, "link status");
      bus(1'b0, IDX_DL_STATUS, 32'h0);
      chk(rd & 32'h1, 32'h0, "link status reread");
      $display("frame test %0d done", c);
    end
    summarize();
  end
endmodule // ftxirq_tx_irq_tb
`default_nettype wire
